// ### verilog/wdt_cfg.svh
/*
 * Constants of the watchdog: control register field positions, reset value,
 * prescale codes and crystal timebase.
 * Assumes it is included by its bare name from the package and the watchdog_timer_control module.
 */
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// Field positions inside the eight-bit control register.
`define WDT_BIT_UNLOCK 0
`define WDT_BIT_ARM 1
`define WDT_BIT_STATUS 2
`define WDT_BIT_IRSEL 3
`define WDT_PRE_MSB 7
`define WDT_PRE_LSB 4

// Value of the control register after a hardware reset.
`define WDT_CTRL_RESET 8'h00

// Prescale codes: up to the last timed code, the immediate reset code.
`define WDT_PRE_LAST_TIMED 4'h7
`define WDT_PRE_IMMEDIATE 4'h8

// Crystal periods per timeout at prescale zero, and counter width.
`define WDT_BASE_TICKS 512
`define WDT_CNT_W 17

// Control value of the usual two-second arm sequence.
`define WDT_CTRL_EXAMPLE 8'h72

`endif

// ### verilog/wdt_pkg.sv
/*
 * Types shared by the watchdog modules: unlock states and state records.
 * Assumes wdt_cfg.svh is on the include path.
 */
`include "wdt_cfg.svh"

package wdt_pkg;

   // One-hot states of the write-unlock sequence.
   typedef enum logic [2:0] {
      UNL_IDLE = 3'h1,
      UNL_SET = 3'h2,
      UNL_OPEN = 3'h4
   } unlock_state_t;

   // Whole state of the crystal edge detector.
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic last;
      logic tick;
   } tick_state_t;

   // Whole state of the watchdog.
   typedef struct packed {
      logic [3:0] pre;
      logic irsel;
      logic status;
      logic arm;
      unlock_state_t unl;
      logic [`WDT_CNT_W-1:0] count;
      logic irq;
      logic rst_req;
   } wdt_state_t;

endpackage : wdt_pkg

// ### verilog/wdt_xtal_tick.sv
/*
 * Crystal tick generator: synchronises the 32.768 kHz crystal pin into the
 * core clock and gives one pulse per rising crystal edge.
 * Assumes clk is far faster than the crystal.
 */
`timescale 1ns/1ps
`default_nettype none

module wdt_xtal_tick
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic xtal_in,
   output logic tick
);

   wdt_pkg::tick_state_t st;
   wdt_pkg::tick_state_t next_st;

   // Two flops synchronise the pin; only the second one feeds the edge test.
   always_comb
   begin
      next_st = st;
      next_st.sync1 = xtal_in;
      next_st.sync2 = st.sync1;
      next_st.last = st.sync2;
      next_st.tick = st.sync2 & ~st.last;
   end

   // Synchronous reset to a quiet, low crystal.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign tick = st.tick;

endmodule : wdt_xtal_tick

`default_nettype wire

// ### verilog/watchdog_timer_control.sv
/*
 * Watchdog timer with its control register, write-unlock sequence, timeout
 * counter on the crystal timebase, and reset or interrupt response.
 * Assumes the core writes the register through ctrl_wr with ctrl_wdata and
 * marks the end of every instruction with instr_end, all on clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"

module watchdog_timer_control
#(
   parameter int BASE_TICKS = `WDT_BASE_TICKS
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic xtal_in,
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   input wire logic instr_end,
   input wire logic supply_monitor_irq,
   output logic [7:0] ctrl_rdata,
   output logic wdt_irq,
   output logic wdt_irq_high_priority,
   output logic wdt_reset_req
);

   wdt_pkg::wdt_state_t st;
   wdt_pkg::wdt_state_t next_st;
   logic tick;
   logic accept;
   logic kick;
   logic timed;
   logic immediate;
   logic expire;
   logic [`WDT_CNT_W:0] limit;

   wdt_xtal_tick u_tick
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .xtal_in(xtal_in),
      .tick(tick)
   );

   // write gating
   // Only the write in the instruction after the unlock reaches the fields.
   assign accept = ctrl_wr && (st.unl == wdt_pkg::UNL_OPEN);
   assign kick = accept && ctrl_wdata[`WDT_BIT_ARM];

   // period length
   // The limit is held one bit wider so that the longest period still fits.
   assign limit = (`WDT_CNT_W+1)'(BASE_TICKS) << st.pre[2:0];
   assign timed = (st.pre <= `WDT_PRE_LAST_TIMED);
   // immediate code
   // Code 8 expires on the first cycle it is armed; reserved codes never do.
   assign immediate = (st.pre == `WDT_PRE_IMMEDIATE);
   // expiry detect
   // A kick in the same cycle wins, so a late refresh is never punished.
   assign expire = st.arm && !kick
      && ((timed && tick && ({1'b0, st.count} == limit - 1'b1)) || immediate);

   // Next-state logic for the register, unlock sequence and counter.
   always_comb
   begin
      next_st = st;
      next_st.irq = 1'b0;
      next_st.rst_req = 1'b0;
      unique case (st.unl)
         wdt_pkg::UNL_IDLE:
         begin
            // An unlock write that also ends its instruction opens the
            // register at once, so the very next instruction can write it.
            if (ctrl_wr && ctrl_wdata[`WDT_BIT_UNLOCK] && instr_end)
            begin
               next_st.unl = wdt_pkg::UNL_OPEN;
            end
            else if (ctrl_wr && ctrl_wdata[`WDT_BIT_UNLOCK])
            begin
               next_st.unl = wdt_pkg::UNL_SET;
            end
         end
         wdt_pkg::UNL_SET:
         begin
            if (instr_end)
            begin
               next_st.unl = wdt_pkg::UNL_OPEN;
            end
         end
         wdt_pkg::UNL_OPEN:
         begin
            if (ctrl_wr || instr_end)
            begin
               next_st.unl = wdt_pkg::UNL_IDLE;
            end
         end
         default:
         begin
            next_st.unl = wdt_pkg::UNL_IDLE;
         end
      endcase
      if (accept)
      begin
         next_st.pre = ctrl_wdata[`WDT_PRE_MSB:`WDT_PRE_LSB];
         next_st.irsel = ctrl_wdata[`WDT_BIT_IRSEL];
         next_st.arm = ctrl_wdata[`WDT_BIT_ARM];
         next_st.status = ctrl_wdata[`WDT_BIT_STATUS];
      end
      // The counter runs on crystal ticks while armed with a timed code and restarts on a kick.
      if (kick || !st.arm)
      begin
         next_st.count = '0;
      end
      else if (tick && timed)
      begin
         next_st.count = st.count + 1'b1;
      end
      if (expire)
      begin
         // status set
         // The set wins over a software clear in the same cycle.
         next_st.status = 1'b1;
         next_st.count = '0;
         if (st.irsel)
         begin
            next_st.irq = 1'b1;
         end
         else
         begin
            next_st.rst_req = 1'b1;
            next_st.arm = 1'b0;
         end
      end
      if (supply_monitor_irq)
      begin
         next_st.arm = 1'b0;
      end
   end

   // hardware reset only
   // The status flag clears only on sys_rst or a software write of 0; the watchdog reset request
   // goes to the system and never comes back into this block.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st.pre <= 4'(`WDT_CTRL_RESET >> `WDT_PRE_LSB);
         st.irsel <= 1'b0;
         st.status <= 1'b0;
         st.arm <= 1'b0;
         st.unl <= wdt_pkg::UNL_IDLE;
         st.count <= '0;
         st.irq <= 1'b0;
         st.rst_req <= 1'b0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Read back: the unlock bit shows while the sequence is in progress.
   assign ctrl_rdata = {st.pre, st.irsel, st.status, st.arm, st.unl != wdt_pkg::UNL_IDLE};
   // fixed priority
   // No global enable input exists, so nothing can mask the request.
   assign wdt_irq = st.irq;
   assign wdt_irq_high_priority = 1'b1;
   assign wdt_reset_req = st.rst_req;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_immediate_reset: assert property (
      (st.arm && immediate && !st.irsel && !kick) |=> wdt_reset_req && !st.arm)
      else $error("Immediate code did not reset.");
   chk_reserved_quiet: assert property (
      (st.pre > `WDT_PRE_IMMEDIATE) |=> !wdt_reset_req && !wdt_irq)
      else $error("Reserved code produced a timeout.");
   chk_irq_not_reset: assert property (
      (expire && st.irsel) |=> wdt_irq && !wdt_reset_req)
      else $error("Interrupt response gave a reset.");
   chk_interval_rearm: assert property (
      (expire && st.irsel && !supply_monitor_irq && !accept) |=> st.arm && st.count == '0)
      else $error("Interval timer did not restart.");
   chk_status_sets: assert property (
      expire |=> st.status ##1 st.status || $past(accept))
      else $error("Timeout did not set status.");
   chk_status_held: assert property (
      (st.status && !(accept && !ctrl_wdata[`WDT_BIT_STATUS])) |=> st.status)
      else $error("Status cleared without a write of 0.");
   chk_arm_restart: assert property (
      (kick && !supply_monitor_irq) |=> st.arm && st.count == '0 && !wdt_reset_req)
      else $error("Arm write did not restart.");
   chk_expire_at_limit: assert property (
      (expire && timed) |-> tick && ({1'b0, st.count} == limit - 1'b1) && st.arm)
      else $error("Expiry at the wrong count.");
   chk_supply_disarm: assert property (
      supply_monitor_irq |=> !st.arm)
      else $error("Supply alarm left the watchdog armed.");
   chk_lock_ignore: assert property (
      (ctrl_wr && st.unl != wdt_pkg::UNL_OPEN) |=> $stable(st.pre) && $stable(st.irsel))
      else $error("Locked write changed the fields.");
   chk_unlock_drop: assert property (
      (st.unl == wdt_pkg::UNL_OPEN && instr_end) |=> st.unl == wdt_pkg::UNL_IDLE)
      else $error("Unlock outlived one instruction.");
   chk_example_value: assert property (
      (accept && ctrl_wdata == `WDT_CTRL_EXAMPLE && !supply_monitor_irq)
      |=> st.pre == `WDT_PRE_LAST_TIMED && st.arm && !st.irsel)
      else $error("Example value did not arm for two seconds.");

   cov_reset_timeout: cover property (expire && !st.irsel);
   cov_interval_irq: cover property (wdt_irq ##[1:1000] wdt_irq);
   cov_example_write: cover property (accept && ctrl_wdata == `WDT_CTRL_EXAMPLE);
   cov_late_write: cover property (st.unl == wdt_pkg::UNL_OPEN && instr_end && !ctrl_wr);

endmodule : watchdog_timer_control

`default_nettype wire

// ### sim/watchdog_timer_control_bench.sv
/*
 * Self-checking bench of the watchdog control block: unlock sequence, both
 * responses, prescale periods, arm and status clearing.
 * Assumes wdt_cfg.svh on the include path; BASE_TICKS is shortened to 4.
 */
`timescale 1ns/1ps
`default_nettype none

module watchdog_timer_control_bench;
   localparam int BT = 4;
   localparam int TP = 16; // Core cycles per crystal period.
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic xtal_in = 1'b0;
   logic ctrl_wr = 1'b0;
   logic instr_end = 1'b0;
   logic supply_monitor_irq = 1'b0;
   logic [7:0] ctrl_wdata = 8'h00;
   logic [7:0] ctrl_rdata;
   logic wdt_irq;
   logic wdt_irq_high_priority;
   logic wdt_reset_req;
   logic [2:0] xc = 3'h0;
   int n_fail = 0;
   int total_checks = 0;
   int n_rst = 0;
   int n;
   int k;

   watchdog_timer_control #(.BASE_TICKS(BT)) i_dut (.clk(clk), .sys_rst(sys_rst),
      .xtal_in(xtal_in), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .instr_end(instr_end),
      .supply_monitor_irq(supply_monitor_irq), .ctrl_rdata(ctrl_rdata), .wdt_irq(wdt_irq),
      .wdt_irq_high_priority(wdt_irq_high_priority), .wdt_reset_req(wdt_reset_req));

   initial
   begin
      forever #4 clk = ~clk;
   end

   // A free-running crystal, far slower than the core so periods stay exact.
   always @(posedge clk)
   begin
      xc <= xc + 3'h1;
      if (xc == 3'h7)
         xtal_in <= ~xtal_in;
      if (wdt_reset_req === 1'b1)
         n_rst++;
   end

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk

   // One instruction that writes the register; an idle cycle follows it.
   // Drivers change on a rising edge and fall back at the edge that samples them.
   task automatic wr(input logic [7:0] d);
      @(posedge clk);
      ctrl_wr <= 1'b1;
      ctrl_wdata <= d;
      instr_end <= 1'b1;
      @(posedge clk);
      ctrl_wr <= 1'b0;
      instr_end <= 1'b0;
      #1;
   endtask : wr

   // unlock then write
   // Nothing, not even an interrupt service, runs between the two instructions.

   task automatic uwr(input logic [7:0] d);
      wr(8'h01);
      wr(d);
   endtask : uwr

   task automatic ins;
      @(posedge clk);
      instr_end <= 1'b1;
      @(posedge clk);
      instr_end <= 1'b0;
      #1;
   endtask : ins

   // Counts edges up to the next pulse; a missing pulse ends the run.
   task automatic wt(input logic irq, input int bound, output int c);
      c = 0;
      do
      begin
         @(posedge clk);
         #1;
         c++;
         if (c > bound)
         begin
            n_fail++;
            $display("MISMATCH pulse wait expected pulse seen none");
            wrap_up();
         end
      end
      while ((irq ? wdt_irq : wdt_reset_req) !== 1'b1);
   endtask : wt

   initial
   begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("reset readback", 8'h00, ctrl_rdata);
      chk("priority", 1'b1, wdt_irq_high_priority);
      wr(8'h72);
      chk("write without unlock", 8'h00, ctrl_rdata);
      wr(8'h01);
      chk("unlock pending", 8'h01, ctrl_rdata);
      ins();
      chk("unlock dropped", 8'h00, ctrl_rdata);
      wr(8'h72);
      chk("late write", 8'h00, ctrl_rdata);
      uwr(8'h72);
      chk("example value", 8'h72, ctrl_rdata);
      uwr(8'h70);
      chk("software disarm", 8'h70, ctrl_rdata);
      $display("Test unlock done");
      uwr(8'h02);
      wt(1'b0, 90, n);
      chk("reset delay", 1'b1, n >= 48 && n <= 70);
      chk("after reset pulse", 8'h04, ctrl_rdata);
      uwr(8'h00);
      chk("status cleared", 8'h00, ctrl_rdata);
      $display("Test reset response done");
      uwr(8'h0A);
      wt(1'b1, 90, n);
      wt(1'b1, 90, n);
      chk("period prescale 0", BT * TP, n);
      chk("irq readback", 8'h0E, ctrl_rdata);
      uwr(8'h1A);
      wt(1'b1, 160, n);
      wt(1'b1, 160, n);
      chk("period prescale 1", 2 * BT * TP, n);
      repeat (32) @(posedge clk);
      uwr(8'h1A);
      wt(1'b1, 160, n);
      chk("kick restarts", 1'b1, n > 104);
      @(posedge clk);
      supply_monitor_irq <= 1'b1;
      @(posedge clk);
      supply_monitor_irq <= 1'b0;
      #1;
      chk("supply alarm", 8'h1C, ctrl_rdata);
      $display("Test irq response done");
      k = n_rst;
      uwr(8'h92);
      repeat (300) @(posedge clk);
      #1;
      chk("reserved code", k, n_rst);
      k = n_rst;
      uwr(8'h82);
      repeat (4) @(posedge clk);
      #1;
      chk("immediate reset count", k + 1, n_rst);
      chk("immediate reset state", 8'h84, ctrl_rdata);
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("hardware reset", 8'h00, ctrl_rdata);
      $display("Test prescale codes done");
      wrap_up();
   end
endmodule : watchdog_timer_control_bench

`default_nettype wire
